// >>> logic/timer_mode_control_irq_regs.sv
// AXI4-Lite register slice for timer mode, control and interrupt status
module timer_mode_control_irq_regs
  import timer_regs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [10:0] event_set,
  output logic             split_mode,
  output logic [3:0]       second_timer_mode_reg,
  output logic             first_timer_enable,
  output logic             first_stall_enable,
  output logic [1:0]       first_edge_select,
  output logic             rtc_count_enable,
  output logic             first_trigger_enable,
  output logic             first_pwm_invert,
  output logic             second_timer_enable,
  output logic             second_stall_enable,
  output logic [1:0]       second_edge_select,
  output logic             second_trigger_enable,
  output logic             second_pwm_invert,
  output logic             irq
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  waddr;
    logic [31:0] wdat;
    logic [3:0]  wstb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [2:0]  config_val;
    logic [3:0]  first_mode;
    logic [3:0]  second_mode;
    logic [31:0] control;
    logic [31:0] mask;
    logic [31:0] raw;
    logic        irq;
    logic        split;
    logic [3:0]  mode_out;
    logic [1:0]  fedge;
    logic [1:0]  sedge;
  } state_t;

  state_t cur;
  state_t next_cur;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] stb, input logic [31:0] wmask);
    logic [31:0] bytes;
    bytes = {{8{stb[3]}}, {8{stb[2]}}, {8{stb[1]}}, {8{stb[0]}}} & wmask;
    return (old & ~bytes) | (val & bytes);
  endfunction : merge

  // Reserved encoding 10 falls back to rising so no undefined edge detection results
  function automatic logic [1:0] edge_map(input logic [1:0] f);
    return (f == 2'h2) ? EDGE_RISE : f;
  endfunction : edge_map

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    logic        do_write;
    logic [31:0] clr;
    logic [31:0] ctl;
    logic        hit;
    next_cur = cur;
    do_write = 1'b0;
    clr      = 32'h0000_0000;
    hit      = 1'b1;
    ctl      = 32'h0000_0000;

    // Write address and data are taken independently, in either order
    if (awvalid && cur.awready) begin
      next_cur.aw_held = 1'b1;
      next_cur.waddr   = awaddr;
      next_cur.awready = 1'b0;
    end
    if (wvalid && cur.wready) begin
      next_cur.w_held = 1'b1;
      next_cur.wdat   = wdata;
      next_cur.wstb   = wstrb;
      next_cur.wready = 1'b0;
    end
    if (cur.aw_held && cur.w_held && !cur.bvalid) begin
      do_write         = 1'b1;
      next_cur.aw_held = 1'b0;
      next_cur.w_held  = 1'b0;
      next_cur.bvalid  = 1'b1;
      next_cur.bresp   = RESP_OKAY;
      case (cur.waddr)
        OFS_CONFIG:      next_cur.config_val  = 3'(merge({29'h0, cur.config_val}, cur.wdat, cur.wstb, 32'h7));
        OFS_FIRST_MODE:  next_cur.first_mode  = 4'(merge({28'h0, cur.first_mode}, cur.wdat, cur.wstb, MODE_WMASK));
        OFS_SECOND_MODE: next_cur.second_mode = 4'(merge({28'h0, cur.second_mode}, cur.wdat, cur.wstb, MODE_WMASK));
        OFS_CONTROL:     next_cur.control     = merge(cur.control, cur.wdat, cur.wstb, CONTROL_WMASK);
        OFS_MASK:        next_cur.mask        = merge(cur.mask, cur.wdat, cur.wstb, IRQ_WMASK);
        OFS_CLEAR:       clr                  = merge(32'h0, cur.wdat, cur.wstb, IRQ_WMASK);
        OFS_RAW,
        OFS_MASKED:      next_cur.bresp       = RESP_OKAY;
        default:         next_cur.bresp       = RESP_SLVERR;
      endcase
    end
    if (cur.bvalid && bready) begin
      next_cur.bvalid  = 1'b0;
      next_cur.awready = 1'b1;
      next_cur.wready  = 1'b1;
    end

    // Read channel: one read under way at a time
    if (arvalid && cur.arready) begin
      next_cur.arready = 1'b0;
      next_cur.rvalid  = 1'b1;
      case (araddr)
        OFS_CONFIG:      next_cur.rdata = {29'h0, cur.config_val};
        OFS_FIRST_MODE:  next_cur.rdata = {28'h0, cur.first_mode};
        OFS_SECOND_MODE: next_cur.rdata = {28'h0, cur.second_mode};
        OFS_CONTROL:     next_cur.rdata = cur.control;
        OFS_MASK:        next_cur.rdata = cur.mask;
        OFS_RAW:         next_cur.rdata = cur.raw;
        OFS_MASKED:      next_cur.rdata = cur.raw & cur.mask;
        OFS_CLEAR:       next_cur.rdata = 32'h0000_0000;
        default: begin
          next_cur.rdata = 32'h0000_0000;
          hit            = 1'b0;
        end
      endcase
      next_cur.rresp = hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (cur.rvalid && rready) begin
      next_cur.rvalid  = 1'b0;
      next_cur.arready = 1'b1;
    end

    // Hardware set wins over a software clear in the same cycle
    next_cur.raw = ((cur.raw & ~clr) | {21'h0, event_set}) & IRQ_WMASK;
    next_cur.irq = |(next_cur.raw & next_cur.mask);
    ctl          = next_cur.control;
    if (!do_write) begin
      ctl = cur.control;
    end
    next_cur.control = ctl;

    // Decoded outputs are registered from the next state so they move with the register itself
    next_cur.split    = (next_cur.config_val == CONFIG_SPLIT);
    next_cur.mode_out = next_cur.split ? next_cur.second_mode : 4'h0;
    next_cur.fedge    = edge_map(next_cur.control[3:2]);
    next_cur.sedge    = edge_map(next_cur.control[11:10]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur         <= '0;
      cur.awready <= 1'b1;
      cur.wready  <= 1'b1;
      cur.arready <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign awready = cur.awready;
  assign wready  = cur.wready;
  assign bvalid  = cur.bvalid;
  assign bresp   = cur.bresp;
  assign arready = cur.arready;
  assign rvalid  = cur.rvalid;
  assign rdata   = cur.rdata;
  assign rresp   = cur.rresp;
  assign irq     = cur.irq;

  // 32-bit configuration makes the second-timer mode register inert
  assign split_mode            = cur.split;
  assign second_timer_mode_reg = cur.mode_out;
  assign first_timer_enable    = cur.control[0];
  assign first_stall_enable    = cur.control[1];
  assign first_edge_select     = cur.fedge;
  assign rtc_count_enable      = cur.control[4];
  assign first_trigger_enable  = cur.control[5];
  assign first_pwm_invert      = cur.control[6];
  assign second_timer_enable   = cur.control[8];
  assign second_stall_enable   = cur.control[9];
  assign second_edge_select    = cur.sedge;
  assign second_trigger_enable = cur.control[13];
  assign second_pwm_invert     = cur.control[14];

endmodule : timer_mode_control_irq_regs

// >>> logic/timer_regs_pkg.sv
// Constants, offsets and field layout of the timer mode, control and interrupt registers
//
// Notes on behaviour
// - Second-timer mode field bits 1:0: 0 reserved, 1 one-shot, 2 periodic, 3 capture.
// - In split 16-bit configuration the mode field drives the second timer.
// - Enable bits 8 and 0 start each timer or arm capture; clear disables.
// - Stall enable bits 9 and 1 permit each timer to stall.
// - Event fields 11:10 and 3:2 select rising, falling or both edges.
// - PWM level bits 14 and 6 pass output when 0, invert when 1.
// - Trigger enable bits 13 and 5 gate each timer's output trigger.
// - Control bit 4 enables real-time-clock counting.
// - Mask bits 10,9,8,3,2,1,0 enable matching interrupts when one.
// - Raw status bits set on events regardless of mask, same positions.
// - Raw status bit stays set until a one is written to clear register.
// - Masked status is raw and mask; the interrupt output follows it.
// - Writing one to clear register clears raw and masked; zero leaves them.
// - In 32-bit configuration the second-timer mode register is ignored.
package timer_regs_pkg;

  // ----------------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG      = 8'h00;
  localparam logic [7:0] OFS_FIRST_MODE  = 8'h04;
  localparam logic [7:0] OFS_SECOND_MODE = 8'h08;
  localparam logic [7:0] OFS_CONTROL     = 8'h0C;
  localparam logic [7:0] OFS_MASK        = 8'h18;
  localparam logic [7:0] OFS_RAW         = 8'h1C;
  localparam logic [7:0] OFS_MASKED      = 8'h20;
  localparam logic [7:0] OFS_CLEAR       = 8'h24;

  // ----------------------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------------------
  localparam logic [31:0] CONTROL_WMASK = 32'h0000_6F7F;
  localparam logic [31:0] IRQ_WMASK     = 32'h0000_070F;
  localparam logic [31:0] MODE_WMASK    = 32'h0000_000F;
  localparam logic [2:0]  CONFIG_SPLIT  = 3'h4;
  localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_BOTH = 2'h3
  } edge_sel_t;

endpackage : timer_regs_pkg

// >>> tb/timer_regs_chk_sva.sv
// Port checker for the timer register slice
module timer_regs_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        bvalid,
  input wire logic [10:0] event_set,
  input wire logic        split_mode,
  input wire logic [3:0]  second_timer_mode_reg,
  input wire logic [1:0]  first_edge_select,
  input wire logic [1:0]  second_edge_select,
  input wire logic        first_timer_enable,
  input wire logic        second_timer_enable,
  input wire logic        rtc_count_enable,
  input wire logic        irq
);
  // --------------------------------------------
  // Properties
  // --------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_edge1; first_edge_select != 2'h2; endproperty
  a_edge1: assert property (p_edge1) else $error("first edge code reserved");
  property p_edge2; second_edge_select != 2'h2; endproperty
  a_edge2: assert property (p_edge2) else $error("second edge code reserved");
  property p_split; !split_mode |-> second_timer_mode_reg == 4'h0; endproperty
  a_split: assert property (p_split) else $error("mode seen outside split");
  property p_mode; $changed(second_timer_mode_reg) |-> $rose(bvalid); endproperty
  a_mode: assert property (p_mode) else $error("mode moved without write");
  property p_cfg; $rose(split_mode) |-> $rose(bvalid); endproperty
  a_cfg: assert property (p_cfg) else $error("split set without write");
  property p_en; $changed({first_timer_enable, second_timer_enable, rtc_count_enable}) |-> $rose(bvalid); endproperty
  a_en: assert property (p_en) else $error("enable moved without write");
  property p_irq_up; $rose(irq) |-> ($past(event_set) != 11'h000) || $rose(bvalid); endproperty
  a_irq_up: assert property (p_irq_up) else $error("irq rose without cause");
  property p_irq_dn; $fell(irq) |-> $rose(bvalid); endproperty
  a_irq_dn: assert property (p_irq_dn) else $error("irq fell without write");
endmodule : timer_regs_chk
bind timer_mode_control_irq_regs timer_regs_chk timer_regs_chk_inst (.aclk(aclk), .aresetn(aresetn),
  .bvalid(bvalid), .event_set(event_set), .split_mode(split_mode), .second_timer_mode_reg(second_timer_mode_reg),
  .first_edge_select(first_edge_select), .second_edge_select(second_edge_select), .irq(irq),
  .first_timer_enable(first_timer_enable), .second_timer_enable(second_timer_enable),
  .rtc_count_enable(rtc_count_enable));

// >>> tb/testbench.sv
// Self-checking bench for the timer register slice
module testbench import timer_regs_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, split_mode;
  logic        fen, fst, rtc, fte, fpi, sen, sst, ste, spi;
  logic [1:0]  bresp, rresp, rsp, fe, se;
  logic [3:0]  wstrb, mode2;
  logic [7:0]  awaddr, araddr;
  logic [10:0] event_set;
  logic [31:0] wdata, rdata, rv, seed;
  int          fails, n_tests, cfg, mod2, ctl, msk, raw;
  `define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
  timer_mode_control_irq_regs timer_mode_control_irq_regs_inst (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq),
    .event_set(event_set), .split_mode(split_mode), .second_timer_mode_reg(mode2), .first_timer_enable(fen),
    .first_stall_enable(fst), .first_edge_select(fe), .rtc_count_enable(rtc), .first_trigger_enable(fte),
    .first_pwm_invert(fpi), .second_timer_enable(sen), .second_stall_enable(sst), .second_edge_select(se),
    .second_trigger_enable(ste), .second_pwm_invert(spi));
  // --------------------------------------------
  // Model and bus tasks
  // --------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [1:0] er(input logic [7:0] a);
    return (a < 8'h28 && a != 8'h10 && a != 8'h14) ? RESP_OKAY : RESP_SLVERR;
  endfunction : er
  function automatic logic [1:0] edg(input logic [1:0] v);
    return (v == 2'h2) ? 2'h0 : v;
  endfunction : edg
  function automatic int mr(input logic [7:0] a);
    case (a)
      OFS_CONFIG:      return cfg;
      OFS_SECOND_MODE: return mod2;
      OFS_CONTROL:     return ctl;
      OFS_MASK:        return msk;
      OFS_RAW:         return raw;
      OFS_MASKED:      return raw & msk;
      default:         return 0;
    endcase
  endfunction : mr
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", er(a), bresp)
    if (a == OFS_CONFIG) cfg = d & 32'h7;
    if (a == OFS_SECOND_MODE) mod2 = d & MODE_WMASK;
    if (a == OFS_CONTROL) ctl = d & CONTROL_WMASK;
    if (a == OFS_MASK) msk = d & IRQ_WMASK;
    if (a == OFS_CLEAR) raw = raw & ~d;
  endtask : wr
  task automatic chk_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    `CHK("rdata", mr(a), rdata)
    `CHK("rresp", er(a), rresp)
  endtask : chk_rd
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // --------------------------------------------
  // Stimulus
  // --------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (6000) @(posedge aclk);
    fails++;
    give_verdict();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, event_set} = '0;
    {fails, n_tests, cfg, mod2, ctl, msk, raw} = '0;
    wstrb = 4'hF;
    seed = 32'h8156;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 11; i++) chk_rd(8'(i * 4));
    $display("reset and map test done");
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      wr(OFS_CONTROL, (i == 4) ? 32'h0 : (seed & 32'hFFFF_F3F3) | (i << 10) | (i << 2));
      `CHK("ctl_out", {ctl[14:13], edg(ctl[11:10]), ctl[9:8], ctl[6:4], edg(ctl[3:2]), ctl[1:0]},
        {spi, ste, se, sst, sen, fpi, fte, rtc, fe, fst, fen})
      if (i != 2) chk_rd(OFS_CONTROL);
    end
    $display("control test done");
    wr(OFS_CONFIG, 32'h4);
    for (int m = 0; m < 16; m += 5) begin
      wr(OFS_SECOND_MODE, m);
      `CHK("mode", mod2, mode2)
    end
    wr(OFS_CONFIG, 32'h0);
    `CHK("mode_off", 0, mode2)
    chk_rd(OFS_SECOND_MODE);
    $display("mode test done");
    wr(OFS_MASK, 32'hFFFF_FFFF);
    chk_rd(OFS_MASK);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      if (k == 1) wr(OFS_MASK, seed);
      @(posedge aclk);
      event_set <= seed[10:0];
      @(posedge aclk);
      event_set <= '0;
      raw = raw | (seed & IRQ_WMASK);
      @(posedge aclk);
      #1;
      `CHK("irq", (raw & msk) != 0, irq)
      chk_rd(OFS_MASKED);
      wr(OFS_RAW, 32'h0);
      chk_rd(OFS_RAW);
      wr(OFS_CLEAR, (k == 3) ? 32'hFFFF_FFFF : lfsr(seed));
      chk_rd(OFS_RAW);
      `CHK("irq_clr", (raw & msk) != 0, irq)
    end
    $display("interrupt test done");
    give_verdict();
  end
endmodule : testbench
